// [bench/serial_line_driver.sv]
// Remote transmitter model driving the receive line
`timescale 1ns/1ns
`default_nettype none
module serial_line_driver (
   input wire logic sys_clk_i,
   input wire logic go_i,
   input wire logic [11:0] frame_i,
   input wire logic [3:0] len_i,
   input wire logic [4:0] spb_i,
   output var logic rxd_o = 1'b1,
   output var logic busy_o = 1'b0
);
   logic [11:0] sh = 12'hFFF;
   logic [3:0] left = 4'h0;
   logic [4:0] cnt = 5'h00;
   logic [4:0] spb = 5'h10;
   // Bits go out LSB first, each held for spb clocks
   always @(posedge sys_clk_i) begin
      if (go_i && !busy_o) begin
         sh <= frame_i;
         left <= len_i;
         spb <= spb_i;
         cnt <= spb_i - 5'h01;
         busy_o <= 1'b1;
         rxd_o <= frame_i[0];
      end else if (busy_o && cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end else if (busy_o && left == 4'h1) begin
         // Line idles high between frames
         busy_o <= 1'b0;
         rxd_o <= 1'b1;
      end else if (busy_o) begin
         sh <= sh >> 1;
         left <= left - 4'h1;
         cnt <= spb - 5'h01;
         rxd_o <= sh[1];
      end
   end
endmodule // serial_line_driver
`default_nettype wire

// [bench/tb_uart_receiver_recovery_errors.sv]
// Self-checking bench for the serial receiver
`timescale 1ns/1ns
`default_nettype none
module tb_uart_receiver_recovery_errors;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, go = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0000_0000, dat_o, r, junk;
   logic [3:0] sel_i = 4'h0, len = 4'h0;
   logic [11:0] fr = 12'hFFF;
   logic [4:0] spb = 5'h10;
   logic [8:0] b, v[4];
   logic rxd_i, busy, ack_o, rx_pin_owned_o;
   logic [31:0] exp_q[$];
   string nm_q[$];
   int miscompares = 0, comparisons = 0, m, n;
   always #2 sys_clk_i = ~sys_clk_i;
   uart_receiver_recovery_errors u_uart_receiver_recovery_errors (.sys_clk_i, .rst_i, .adr_i,
      .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .rxd_i, .dat_o, .ack_o, .rx_pin_owned_o);
   serial_line_driver u_serial_line_driver (.sys_clk_i, .go_i(go), .frame_i(fr), .len_i(len),
      .spb_i(spb), .rxd_o(rxd_i), .busy_o(busy));
   task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
      comparisons++;
      if (seen !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
      end
   endtask
   always @(posedge sys_clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && nm_q.size() > 0) check(nm_q.pop_front(), dat_o,
         exp_q.pop_front());
   end
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge sys_clk_i);
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      sel_i <= 4'hF;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      k = 0;
      do begin @(posedge sys_clk_i); k++; end while (ack_o !== 1'b1 && k < 100);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (k >= 100) miscompares++;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      wb(a, 1'b1, d, r);
   endtask
   task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      nm_q.push_back(nm);
      exp_q.push_back(e);
      wb(a, 1'b0, 32'h0000_0000, r);
   endtask
   // A bad frame carries a low stop bit and, when parity is on, a wrong parity bit
   task send(input logic [8:0] d, input int nd, input logic [1:0] pm, input logic bad,
      input logic [4:0] s);
      logic [11:0] f;
      logic p;
      int k;
      f = 12'hFFE;
      p = pm[0] ^ bad;
      for (k = 0; k < nd; k++) begin
         f[k+1] = d[k];
         p = p ^ d[k];
      end
      k = nd + 1;
      if (pm[1]) begin
         f[k] = p;
         k++;
      end
      f[k] = !bad;
      @(posedge sys_clk_i);
      fr <= f;
      len <= 4'(k + 1);
      spb <= s;
      go <= 1'b1;
      @(posedge sys_clk_i);
      go <= 1'b0;
      k = 0;
      do begin @(posedge sys_clk_i); k++; end while (busy === 1'b1 && k < 400);
      if (k >= 400) miscompares++;
   endtask
   task tally_and_finish;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      miscompares++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'hDB12_51E5));
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd("control", 8'h04, 32'h0);
      rd("format", 8'h08, 32'h6);
      rd("baud", 8'h10, 32'hF);
      rd("unmapped", 8'h14, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h04, 32'h10);
      $display("register test done");
      for (m = 0; m < 8; m++) begin
         b = 9'($urandom);
         wr(8'h08, {m[1:0], m[2], 3'h6});
         send(b, 8, m[1:0], m[2], 5'h10);
         // Zeros written over a stored frame error: the flag must not move
         if (m[2]) wr(8'h00, 32'h0);
         rd("status", 8'h00, {24'h0, 1'b1, 2'b0, m[2], 1'b0, m[1] & m[2], 2'b0});
         rd("data", 8'h0C, {24'h0, b[7:0]});
      end
      wr(8'h08, 32'h26);
      send(b, 8, 2'b10, 1'b1, 5'h10);
      wr(8'h08, 32'h6);
      rd("status", 8'h00, 32'h90);
      rd("data", 8'h0C, {24'h0, b[7:0]});
      $display("parity and frame test done");
      wr(8'h00, 32'h2);
      send(b, 8, 2'b00, 1'b0, 5'h08);
      rd("status", 8'h00, 32'h82);
      rd("data", 8'h0C, {24'h0, b[7:0]});
      wr(8'h00, 32'h0);
      // Short low spike must be dropped, then a real frame follows
      send(9'h000, 0, 2'b00, 1'b0, 5'h08);
      send(b, 8, 2'b00, 1'b0, 5'h10);
      rd("status", 8'h00, 32'h80);
      rd("data", 8'h0C, {24'h0, b[7:0]});
      $display("speed and noise test done");
      for (m = 0; m < 4; m++) begin
         v[m] = 9'($urandom);
         send(v[m], 8, 2'b00, 1'b0, 5'h10);
      end
      rd("status", 8'h00, 32'h80);
      rd("data", 8'h0C, {24'h0, v[0][7:0]});
      rd("status", 8'h00, 32'h80);
      rd("data", 8'h0C, {24'h0, v[1][7:0]});
      rd("status", 8'h00, 32'h88);
      rd("data", 8'h0C, {24'h0, v[3][7:0]});
      rd("status", 8'h00, 32'h00);
      $display("overrun test done");
      send(9'($urandom), 8, 2'b00, 1'b0, 5'h10);
      send(9'($urandom), 8, 2'b00, 1'b0, 5'h10);
      n = 0;
      do begin
         wb(8'h00, 1'b0, 32'h0, r);
         if (r[7]) wb(8'h0C, 1'b0, 32'h0, junk);
         n++;
      end while (r[7] === 1'b1 && n < 4);
      rd("status", 8'h00, 32'h00);
      send(9'($urandom), 8, 2'b00, 1'b0, 5'h10);
      send(9'($urandom), 8, 2'b00, 1'b0, 5'h10);
      wr(8'h04, 32'h0);
      rd("status", 8'h00, 32'h00);
      check("owned", {31'h0, rx_pin_owned_o}, 32'h0);
      wr(8'h04, 32'h14);
      check("owned", {31'h0, rx_pin_owned_o}, 32'h1);
      b = 9'($urandom) | 9'h100;
      send(b, 9, 2'b00, 1'b0, 5'h10);
      rd("control", 8'h04, 32'h16);
      rd("data", 8'h0C, {24'h0, b[7:0]});
      $display("flush, disable and ninth bit test done");
      @(posedge sys_clk_i);
      tally_and_finish;
   end
endmodule // tb_uart_receiver_recovery_errors
bind uart_receiver_recovery_errors uart_rx_chk u_uart_rx_chk (.sys_clk_i, .rst_i, .adr_i, .dat_i,
   .sel_i, .we_i, .cyc_i, .stb_i, .rxd_i, .dat_o, .ack_o, .rx_pin_owned_o);
`default_nettype wire

// [bench/uart_rx_chk.sv]
// Port-level assertions for the serial receiver
`timescale 1ns/1ns
`default_nettype none
module uart_rx_chk (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic rxd_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic rx_pin_owned_o
);
   logic par_en_ff;
   // Tracks the parity enable that software last wrote
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) par_en_ff <= 1'b0;
      else if (ack_o && we_i && adr_i == 8'h08 && sel_i[0]) par_en_ff <= dat_i[5];
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take; cyc_i && stb_i && !ack_o; endsequence
   sequence s_answer; ack_o ##1 !ack_o; endsequence
   sequence s_ctl_wr; ack_o && we_i && adr_i == 8'h04 && sel_i[0]; endsequence
   property p_handshake; s_take |=> s_answer; endproperty
   property p_ack_cause; ack_o |-> $past(stb_i); endproperty
   property p_unmapped; ack_o && !we_i && !(adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})
      |-> dat_o == 32'h0000_0000; endproperty
   property p_empty_flags; ack_o && !we_i && adr_i == 8'h00 && !dat_o[7] |-> dat_o[4:2] == 3'h0;
   endproperty
   property p_par_mask; ack_o && !we_i && adr_i == 8'h00 && !par_en_ff |-> !dat_o[2]; endproperty
   property p_owned_off; s_ctl_wr and !dat_i[4] |-> ##[1:3] !rx_pin_owned_o; endproperty
   property p_owned_on; s_ctl_wr and dat_i[4] |-> ##[1:3] rx_pin_owned_o; endproperty
   property p_reset_quiet; $fell(rst_i) |-> !ack_o && dat_o == 32'h0000_0000 && !rx_pin_owned_o;
   endproperty
   a_handshake: assert property (p_handshake) else $error("bus request not answered in one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read returned nonzero");
   a_empty_flags: assert property (p_empty_flags) else $error("error flags set with fifo empty");
   a_par_mask: assert property (p_par_mask) else $error("parity flag seen while disabled");
   a_owned_off: assert property (p_owned_off) else $error("pin kept after disable");
   a_owned_on: assert property (p_owned_on) else $error("pin not taken after enable");
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");
endmodule // uart_rx_chk
`default_nettype wire

// [rtl/uart_receiver_recovery_errors.sv]
// Serial receiver: clock and data recovery, two-entry receive FIFO, Wishbone registers
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "uart_rx_defs.svh"

module uart_receiver_recovery_errors
   import uart_rx_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic rxd_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic rx_pin_owned_o
);

   rx_regs_t st_ff;
   rx_regs_t nxt_st;

   always_comb begin
      logic req;
      logic tick;
      logic [4:0] spb;
      logic [4:0] v_first;
      logic [4:0] v_last;
      logic [4:0] k;
      logic [1:0] highs_now;
      logic maj;
      logic [3:0] nbits;
      logic [3:0] frame_bits;
      logic exp_par;
      logic pop;
      logic push;
      rx_entry_t head;
      rx_entry_t done;
      req = 1'b0;
      tick = 1'b0;
      spb = `SPB_NORMAL;
      v_first = `VOTE_FIRST_NORMAL;
      v_last = `VOTE_LAST_NORMAL;
      k = 5'h01;
      highs_now = 2'h0;
      maj = 1'b0;
      nbits = `MIN_CHAR_BITS;
      frame_bits = `MIN_CHAR_BITS;
      exp_par = 1'b0;
      pop = 1'b0;
      push = 1'b0;
      head = st_ff.fifo[st_ff.rd_ptr];
      done = '0;
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;

      // Bus slave: one wait state, ack stands one cycle and never back to back
      req = cyc_i && stb_i && !st_ff.ack;
      if (req) begin
         nxt_st.ack = 1'b1;
         nxt_st.dat = '0;
         if (we_i) begin
            if (adr_i == `OFS_STATUS) begin
               // Error flag positions are not writable; only the speed select is
               if (sel_i[0]) begin
                  nxt_st.double_speed_select = dat_i[`ST_U2X];
               end
            end else if (adr_i == `OFS_CONTROL) begin
               if (sel_i[0]) begin
                  nxt_st.receiver_enable_bit = dat_i[`CT_RXEN];
                  nxt_st.size9 = dat_i[`CT_SIZE9];
               end
            end else if (adr_i == `OFS_FORMAT) begin
               if (sel_i[0]) begin
                  nxt_st.parity_enable_bit = dat_i[`FM_PAR_EN];
                  nxt_st.parity_odd_even_select = dat_i[`FM_PAR_ODD];
                  nxt_st.stop_bit_count_select = dat_i[`FM_STOP_SEL];
                  nxt_st.size = dat_i[`FM_SIZE_HI:`FM_SIZE_LO];
               end
            end else if (adr_i == `OFS_BAUD) begin
               if (sel_i[0]) begin
                  nxt_st.baud[7:0] = dat_i[7:0];
               end
               if (sel_i[1]) begin
                  nxt_st.baud[11:8] = dat_i[11:8];
               end
            end
         end else begin
            if (adr_i == `OFS_STATUS) begin
               nxt_st.dat[`ST_RXC] = (st_ff.cnt != 2'h0);
               nxt_st.dat[`ST_U2X] = st_ff.double_speed_select;
               if (st_ff.cnt != 2'h0) begin
                  // Flags shown belong to the frame at the read position
                  nxt_st.dat[`ST_FE] = head.frame_error_flag;
                  nxt_st.dat[`ST_DOR] = head.overrun_flag;
                  nxt_st.dat[`ST_UPE] = head.parity_error_flag
                                        && st_ff.parity_enable_bit;
               end
            end else if (adr_i == `OFS_CONTROL) begin
               nxt_st.dat[`CT_RXEN] = st_ff.receiver_enable_bit;
               nxt_st.dat[`CT_SIZE9] = st_ff.size9;
               nxt_st.dat[`CT_RXB8] = (st_ff.cnt != 2'h0) && head.data[8];
            end else if (adr_i == `OFS_FORMAT) begin
               nxt_st.dat[`FM_PAR_EN] = st_ff.parity_enable_bit;
               nxt_st.dat[`FM_PAR_ODD] = st_ff.parity_odd_even_select;
               nxt_st.dat[`FM_STOP_SEL] = st_ff.stop_bit_count_select;
               nxt_st.dat[`FM_SIZE_HI:`FM_SIZE_LO] = st_ff.size;
            end else if (adr_i == `OFS_DATA) begin
               if (st_ff.cnt != 2'h0) begin
                  nxt_st.dat[7:0] = head.data[7:0];
                  pop = 1'b1;
               end
            end else if (adr_i == `OFS_BAUD) begin
               nxt_st.dat[11:0] = st_ff.baud;
            end
         end
      end

      // Oversampling tick from the divider; speed select sets samples per bit
      tick = (st_ff.pre == 12'h000);
      nxt_st.pre = tick ? st_ff.baud : st_ff.pre - 12'h001;
      if (st_ff.double_speed_select) begin
         spb = `SPB_DOUBLE;
         v_first = `VOTE_FIRST_DOUBLE;
         v_last = `VOTE_LAST_DOUBLE;
      end
      nbits = st_ff.size9 ? `NINE_BITS : `MIN_CHAR_BITS + {2'h0, st_ff.size};
      frame_bits = nbits + {3'h0, st_ff.parity_enable_bit};

      // Move a finished character into the FIFO when a slot is free
      if (st_ff.hold_v && (st_ff.cnt < `FIFO_DEPTH || pop)) begin
         push = 1'b1;
         nxt_st.fifo[st_ff.wr_ptr] = st_ff.hold;
         nxt_st.fifo[st_ff.wr_ptr].overrun_flag = st_ff.ovr_pend;
         nxt_st.wr_ptr = ~st_ff.wr_ptr;
         nxt_st.hold_v = 1'b0;
         nxt_st.ovr_pend = 1'b0;
      end
      if (pop) begin
         nxt_st.rd_ptr = ~st_ff.rd_ptr;
      end
      if (push && !pop) begin
         nxt_st.cnt = st_ff.cnt + 2'h1;
      end else if (pop && !push) begin
         nxt_st.cnt = st_ff.cnt - 2'h1;
      end

      // Sample number of this tick and running count of high votes
      k = (st_ff.smp == spb) ? 5'h01 : st_ff.smp + 5'h01;
      if (k == v_first) begin
         highs_now = {1'b0, rxd_i};
      end else begin
         highs_now = st_ff.highs + {1'b0, rxd_i};
      end
      maj = (highs_now >= 2'h2);

      if (tick) begin
         case (st_ff.st)
            RX_IDLE: begin
               nxt_st.last_high = rxd_i;
               if (st_ff.last_high && !rxd_i) begin
                  nxt_st.st = RX_START;
                  nxt_st.smp = 5'h01;
                  nxt_st.shift = '0;
                  nxt_st.par_bit = 1'b0;
                  nxt_st.bit_idx = 4'h0;
                  if (st_ff.hold_v && !push && st_ff.cnt == `FIFO_DEPTH) begin
                     nxt_st.ovr_pend = 1'b1;
                  end
               end
            end
            RX_START: begin
               nxt_st.smp = k;
               if (k >= v_first && k <= v_last) begin
                  nxt_st.highs = highs_now;
               end
               if (k == v_last && maj) begin
                  // Noise spike: back to edge search, line seen high again
                  nxt_st.st = RX_IDLE;
                  nxt_st.last_high = rxd_i;
               end else if (k == spb) begin
                  nxt_st.st = RX_DATA;
               end
            end
            RX_DATA: begin
               nxt_st.smp = k;
               if (k >= v_first && k <= v_last) begin
                  nxt_st.highs = highs_now;
               end
               if (k == v_last) begin
                  if (st_ff.bit_idx < nbits) begin
                     nxt_st.shift[st_ff.bit_idx] = maj;
                  end else begin
                     nxt_st.par_bit = maj;
                  end
               end
               if (k == spb) begin
                  nxt_st.bit_idx = st_ff.bit_idx + 4'h1;
                  if (st_ff.bit_idx + 4'h1 == frame_bits) begin
                     nxt_st.st = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               nxt_st.smp = k;
               if (k >= v_first && k <= v_last) begin
                  nxt_st.highs = highs_now;
               end
               // Only the first stop bit is examined; no wait for a second
               if (k == v_last) begin
                  exp_par = (^st_ff.shift) ^ st_ff.parity_odd_even_select;
                  done.data = st_ff.shift;
                  done.frame_error_flag = !maj;
                  done.parity_error_flag = st_ff.parity_enable_bit
                                           && (exp_par != st_ff.par_bit);
                  nxt_st.hold = done;
                  nxt_st.hold_v = 1'b1;
                  nxt_st.st = RX_IDLE;
                  // Double speed needs a high sample before the next edge counts
                  nxt_st.last_high = st_ff.double_speed_select ? 1'b0 : maj;
               end
            end
            default: begin
               nxt_st.st = RX_IDLE;
            end
         endcase
      end

      // Disabled receiver: abandon frame, drop FIFO and shift contents
      if (!st_ff.receiver_enable_bit) begin
         nxt_st.st = RX_IDLE;
         nxt_st.last_high = 1'b0;
         nxt_st.hold_v = 1'b0;
         nxt_st.ovr_pend = 1'b0;
         nxt_st.cnt = 2'h0;
         nxt_st.wr_ptr = 1'b0;
         nxt_st.rd_ptr = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
         st_ff.st <= RX_IDLE;
         st_ff.baud <= `RST_BAUD;
         st_ff.pre <= `RST_BAUD;
         st_ff.size <= `RST_SIZE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // No interrupt output exists for the error flags
   assign dat_o = st_ff.dat;
   assign ack_o = st_ff.ack;
   assign rx_pin_owned_o = st_ff.receiver_enable_bit;

endmodule // uart_receiver_recovery_errors
`default_nettype wire

// [rtl/uart_rx_defs.svh]
// Register map, field positions, reset values and sampling counts of the serial receiver
// What this block does
// - Error flags travel in the receive FIFO entry of their own frame.
// - Register writes never change the three stored receive error flags.
// - Frame error, overrun and parity error never raise an interrupt.
// - Frame error is one when the first stop bit was sampled low.
// - Only the first stop bit is checked; the stop-bit count has no effect.
// - Overrun when FIFO full, shift register holds a char and a start arrives.
// - Overrun indication clears once a frame moves from shift register to FIFO.
// - Upper parity-mode bit enables checking; lower bit selects odd or even.
// - Received parity is compared and the mismatch stored with data and stop bit.
// - Parity error only if checking enabled at reception; valid until data read.
// - Parity error reads zero whenever parity checking is disabled.
// - Clearing receiver enable abandons reception at once and releases the pin.
// - Disabling the receiver empties the FIFO and discards unread entries.
// - Line sampled at sixteen times baud, eight times in double speed.
// - A high-to-low transition on the idle line starts detection at sample one.
// - Start qualified by majority of samples 8-10 or 4-6; noise resumes search.
// - Bit recovery runs sixteen states per bit, eight in double speed.
// - Each bit is the majority of three centre samples; low stop sets frame error.
// - Next start edge accepted right after stop voting; later in double speed.
// - Receive-complete reads one while the FIFO holds unread data.
// - The ninth data bit is stored in the FIFO entry and advances with it.
`ifndef UART_RX_DEFS_SVH
`define UART_RX_DEFS_SVH

`define OFS_STATUS 8'h00
`define OFS_CONTROL 8'h04
`define OFS_FORMAT 8'h08
`define OFS_DATA 8'h0C
`define OFS_BAUD 8'h10

`define ST_RXC 7
`define ST_FE 4
`define ST_DOR 3
`define ST_UPE 2
`define ST_U2X 1
`define CT_RXEN 4
`define CT_SIZE9 2
`define CT_RXB8 1
`define FM_PAR_EN 5
`define FM_PAR_ODD 4
`define FM_STOP_SEL 3
`define FM_SIZE_HI 2
`define FM_SIZE_LO 1

`define RST_BAUD 12'h000F
`define RST_SIZE 2'h3

`define SPB_NORMAL 5'h10
`define SPB_DOUBLE 5'h08
`define VOTE_FIRST_NORMAL 5'h08
`define VOTE_LAST_NORMAL 5'h0A
`define VOTE_FIRST_DOUBLE 5'h04
`define VOTE_LAST_DOUBLE 5'h06
`define FIFO_DEPTH 2'h2
`define MIN_CHAR_BITS 4'h5
`define NINE_BITS 4'h9

`endif

// [rtl/uart_rx_pkg.sv]
// Types shared by the serial receiver
package uart_rx_pkg;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } rx_state_t;

   typedef struct packed {
      logic [8:0] data;
      logic frame_error_flag;
      logic overrun_flag;
      logic parity_error_flag;
   } rx_entry_t;

   typedef struct packed {
      rx_state_t st;
      logic [4:0] smp;
      logic [3:0] bit_idx;
      logic [1:0] highs;
      logic [8:0] shift;
      logic par_bit;
      logic last_high;
      rx_entry_t hold;
      logic hold_v;
      logic ovr_pend;
      rx_entry_t [1:0] fifo;
      logic wr_ptr;
      logic rd_ptr;
      logic [1:0] cnt;
      logic [11:0] pre;
      logic [11:0] baud;
      logic double_speed_select;
      logic receiver_enable_bit;
      logic size9;
      logic [1:0] size;
      logic parity_enable_bit;
      logic parity_odd_even_select;
      logic stop_bit_count_select;
      logic [31:0] dat;
      logic ack;
   } rx_regs_t;

endpackage
